/* adc_core_model.sv */
// Purpose: Stand-in for the analog core on the far side of the control block
// Assumes: Core latches one result on every sample_strobe pulse
// Notes: Passive; counts results so the bench can see extra or missing ones
`timescale 1ns/1ps
`default_nettype none
module adc_core_model
  import adc_ctl_pkg::*;
(
  input wire logic core_clk,
  input wire analog_ctl_type analog_ctl,
  input wire logic sample_strobe,
  output int result_count
);
  // Results latched; a strobe while every switch is open is still counted
  initial result_count = 0;
  always @(posedge core_clk) begin
    if (sample_strobe) begin
      result_count <= result_count + 1;
    end
  end
endmodule
`default_nettype wire

/* adc_ctl.sv */
// Purpose: Converter control register zero, sequencing and completion interrupt
// Assumes: Register port with read data one cycle after the read strobe
// Notes: Counter limits are parameters so simulation can shorten them
`timescale 1ns/1ps
`default_nettype none
module adc_ctl
  import adc_ctl_pkg::*;
#(
  parameter int SINGLE_COUNT = SINGLE_CYCLES,
  parameter int CONTINUOUS_MODE_COUNT = CONTINUOUS_MODE_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output analog_ctl_type analog_ctl,
  output logic sample_strobe,
  output logic [3:0] input_channel_select,
  output logic ref_pin_oe,
  output logic irq
);

  localparam int CW = 13;

  logic [7:0] ctl0_q;
  logic ref_high_q;
  logic irq_status_q;
  logic irq_mask_q;
  logic [CW-1:0] cnt_q;
  conv_state_type state_q;
  logic [7:0] rdata_q;
  logic done_q;

  logic wr_ctl0;
  logic start;
  logic done;
  logic [1:0] ref_pair;

  assign wr_ctl0 = reg_wr && (reg_addr == CTL0_OFFSET);
  assign start = wr_ctl0 && reg_wdata[ENABLE_BIT];
  assign ref_pair = {ref_high_q, ctl0_q[REF_LOW_BIT]};

  // Completion: first result at the single count, then every continuous period
  assign done = !start && (((state_q == FIRST_ST) && (cnt_q == CW'(SINGLE_COUNT - 1))) ||
                           ((state_q == CONTINUOUS_MODE_ST) && (cnt_q == CW'(CONTINUOUS_MODE_COUNT - 1))));

  // Sequencer; a start always wins, so a restart begins a fresh count
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_q <= IDLE_ST;
    end else if (start) begin
      state_q <= FIRST_ST;
    end else begin
      case (state_q)
        FIRST_ST: if (done) state_q <= ctl0_q[CONTINUOUS_MODE_BIT] ? CONTINUOUS_MODE_ST : IDLE_ST;
        CONTINUOUS_MODE_ST: if (!ctl0_q[CONTINUOUS_MODE_BIT]) state_q <= IDLE_ST;
        default: state_q <= IDLE_ST;
      endcase
    end
  end

  // Cycle counter, cleared on every start and every completion
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (start || done || state_q == IDLE_ST) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

  // Control register zero; enable bit only set by a written one, cleared by hardware
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ctl0_q <= CTL0_RESET;
    end else begin
      if (wr_ctl0) begin
        ctl0_q[6:0] <= reg_wdata[6:0];
      end
      if (start) begin
        ctl0_q[ENABLE_BIT] <= 1'b1;
      end else if (done && state_q == FIRST_ST) begin
        ctl0_q[ENABLE_BIT] <= 1'b0;
      end
    end
  end

  // High reference bit lives in the second control register
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ref_high_q <= CTL1_RESET[REF_HIGH_BIT];
    end else if (reg_wr && reg_addr == CTL1_OFFSET) begin
      ref_high_q <= reg_wdata[REF_HIGH_BIT];
    end
  end

  // Sticky completion flag; a new completion beats a clearing write
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      irq_status_q <= 1'b0;
      irq_mask_q <= 1'b0;
    end else begin
      if (done) begin
        irq_status_q <= 1'b1;
      end else if (reg_wr && reg_addr == IRQ_STATUS_OFFSET && reg_wdata[0]) begin
        irq_status_q <= 1'b0;
      end
      if (reg_wr && reg_addr == IRQ_MASK_OFFSET) begin
        irq_mask_q <= reg_wdata[0];
      end
    end
  end

  // Result strobe registered so it stands one cycle after completion
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      done_q <= 1'b0;
    end else begin
      done_q <= done;
    end
  end

  // Read port; unmapped addresses read zero
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        CTL0_OFFSET: rdata_q <= ctl0_q;
        CTL1_OFFSET: rdata_q <= {7'h00, ref_high_q};
        IRQ_STATUS_OFFSET: rdata_q <= {7'h00, irq_status_q};
        IRQ_MASK_OFFSET: rdata_q <= {7'h00, irq_mask_q};
        default: rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  // Input switch decode; reserved codes open every switch
  function automatic logic [7:0] switch_decode(input logic [3:0] sel);
    logic [7:0] s;
    s = 8'h00;
    if (sel <= LAST_CHANNEL) begin
      s[sel[2:0]] = 1'b1;
    end
    return s;
  endfunction

  assign reg_rdata = rdata_q;
  assign sample_strobe = done_q;
  assign input_channel_select = ctl0_q[3:0];
  assign analog_ctl.switch_on = switch_decode(ctl0_q[3:0]);
  assign analog_ctl.internal_ref_on = (ref_pair != REF_EXTERNAL);
  assign analog_ctl.ref_level = ref_pair;
  assign analog_ctl.ref_buffer_on = ctl0_q[REF_PIN_BIT];
  assign ref_pin_oe = ctl0_q[REF_PIN_BIT];
  assign irq = irq_status_q && irq_mask_q;

  a_single_done_time: assert property (@(posedge core_clk) disable iff (!rst_n)
    start ##1 (!start && !ctl0_q[CONTINUOUS_MODE_BIT]) [*3] |-> !done_q);
  a_enable_sets: assert property (@(posedge core_clk) disable iff (!rst_n)
    start |=> ctl0_q[ENABLE_BIT] && state_q == FIRST_ST && cnt_q == '0);
  a_zero_no_effect: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wr_ctl0 && !reg_wdata[ENABLE_BIT] && !done) |=> ctl0_q[ENABLE_BIT] == $past(ctl0_q[ENABLE_BIT]));
  a_enable_clears: assert property (@(posedge core_clk) disable iff (!rst_n)
    (done && state_q == FIRST_ST) |=> !ctl0_q[ENABLE_BIT] && done_q);
  a_restart_count: assert property (@(posedge core_clk) disable iff (!rst_n)
    (start && state_q != IDLE_ST) |=> cnt_q == '0 && state_q == FIRST_ST);
  a_continuous_mode_period: assert property (@(posedge core_clk) disable iff (!rst_n)
    (done && state_q == CONTINUOUS_MODE_ST && ctl0_q[CONTINUOUS_MODE_BIT]) |=> (state_q == CONTINUOUS_MODE_ST) [*1] ##0 !done);
  a_irq_sticky: assert property (@(posedge core_clk) disable iff (!rst_n)
    done |=> irq_status_q);
  a_ref_pin: assert property (@(posedge core_clk) disable iff (!rst_n)
    !ctl0_q[REF_PIN_BIT] |-> !ref_pin_oe && !analog_ctl.ref_buffer_on);
  a_ref_external: assert property (@(posedge core_clk) disable iff (!rst_n)
    ref_pair == REF_EXTERNAL |-> !analog_ctl.internal_ref_on);
  a_reserved_open: assert property (@(posedge core_clk) disable iff (!rst_n)
    ctl0_q[3] |-> analog_ctl.switch_on == 8'h00);
  a_continuous_mode_enable_low: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state_q == CONTINUOUS_MODE_ST && !start) |-> !ctl0_q[ENABLE_BIT]);

  // Shadow timer for the checks below; independent of the sequencer counter
  // so a slip in the main count cannot hide behind its own reference
  localparam int SW = CW + 1;
  logic [SW-1:0] span_q;
  logic span_armed_q;

  // Counts edges since the last start and saturates instead of wrapping
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      span_q <= '0;
      span_armed_q <= 1'b0;
    end else if (start) begin
      span_q <= '0;
      span_armed_q <= 1'b1;
    end else if (span_q != '1) begin
      span_q <= span_q + SW'(1);
    end
  end

  // First result exactly one single-shot span after the start
  a_single_exact: assert property (@(posedge core_clk) disable iff (!rst_n)
    (span_armed_q && span_q == SW'(SINGLE_COUNT)) |-> sample_strobe);

  // No result before the single-shot span has run out
  a_single_not_early: assert property (@(posedge core_clk) disable iff (!rst_n)
    (span_armed_q && sample_strobe) |-> span_q >= SW'(SINGLE_COUNT));

  // Idle keeps the counter parked at zero
  a_idle_count_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state_q == IDLE_ST && !start) |=> cnt_q == '0);

  // Running counter steps by one each cycle
  a_count_step: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state_q != IDLE_ST && !start && !done) |=> cnt_q == $past(cnt_q) + CW'(1));

  // Completion restarts the count for the next period
  a_done_clears_count: assert property (@(posedge core_clk) disable iff (!rst_n)
    done |=> cnt_q == '0);

  // Any start restarts the count
  a_start_clears_count: assert property (@(posedge core_clk) disable iff (!rst_n)
    start |=> cnt_q == '0);

  // First conversion never counts past its end
  a_first_bound: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state_q == FIRST_ST) |-> cnt_q <= CW'(SINGLE_COUNT - 1));

  // Continuous period never counts past its end
  a_continuous_mode_bound: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state_q == CONTINUOUS_MODE_ST) |-> cnt_q <= CW'(CONTINUOUS_MODE_COUNT - 1));

  // End of the first count completes unless a start arrives in that cycle
  a_done_single: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state_q == FIRST_ST && cnt_q == CW'(SINGLE_COUNT - 1) && !start) |-> done);

  // End of each continuous period completes unless a start arrives in that cycle
  a_done_continuous_mode: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state_q == CONTINUOUS_MODE_ST && cnt_q == CW'(CONTINUOUS_MODE_COUNT - 1) && !start) |-> done);

  // No completion while nothing runs
  a_done_only_counted: assert property (@(posedge core_clk) disable iff (!rst_n)
    done |-> state_q != IDLE_ST);

  // Every completion hands one result to the core
  a_strobe_follows: assert property (@(posedge core_clk) disable iff (!rst_n)
    done |=> sample_strobe);

  // No result without a completion behind it
  a_strobe_source: assert property (@(posedge core_clk) disable iff (!rst_n)
    sample_strobe |-> $past(done));

  // Strobe is a single-cycle pulse
  a_strobe_single_pulse: assert property (@(posedge core_clk) disable iff (!rst_n)
    sample_strobe |=> !sample_strobe);

  // First result moves on to continuous updates when asked
  a_first_to_continuous_mode: assert property (@(posedge core_clk) disable iff (!rst_n)
    (done && state_q == FIRST_ST && ctl0_q[CONTINUOUS_MODE_BIT]) |=> state_q == CONTINUOUS_MODE_ST);

  // Single-shot goes quiet after its one result
  a_first_to_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
    (done && state_q == FIRST_ST && !ctl0_q[CONTINUOUS_MODE_BIT]) |=> state_q == IDLE_ST);

  // Clearing the mode bit stops continuous updates
  a_continuous_mode_stop: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state_q == CONTINUOUS_MODE_ST && !ctl0_q[CONTINUOUS_MODE_BIT] && !start) |=> state_q == IDLE_ST);

  // Nothing starts on its own
  a_no_start_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state_q == IDLE_ST && !start) |=> state_q == IDLE_ST);

  // Enable bit is low whenever nothing runs
  a_idle_enable_low: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_q == IDLE_ST |-> !ctl0_q[ENABLE_BIT]);

  // Enable bit is high throughout a first conversion
  a_first_enable_high: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_q == FIRST_ST |-> ctl0_q[ENABLE_BIT]);

  // Software sees the live enable bit
  a_enable_read: assert property (@(posedge core_clk) disable iff (!rst_n)
    (reg_rd && reg_addr == CTL0_OFFSET) |=> reg_rdata == $past(ctl0_q));

  // A start during continuous updates begins a fresh first conversion
  a_restart_continuous_mode: assert property (@(posedge core_clk) disable iff (!rst_n)
    (start && state_q == CONTINUOUS_MODE_ST) |=> state_q == FIRST_ST && ctl0_q[ENABLE_BIT]);

  // A zero write leaves a running conversion alone
  a_zero_keeps_run: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wr_ctl0 && !reg_wdata[ENABLE_BIT] && state_q == FIRST_ST && !done) |=> state_q == FIRST_ST);

  // Low fields take the written value
  a_fields_written: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_ctl0 |=> ctl0_q[6:0] == $past(reg_wdata[6:0]));

  // Low fields hold without a write
  a_fields_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    !wr_ctl0 |=> ctl0_q[6:0] == $past(ctl0_q[6:0]));

  // Channel output mirrors the select field
  a_channel_out: assert property (@(posedge core_clk) disable iff (!rst_n)
    input_channel_select == ctl0_q[3:0]);

  // Valid codes close exactly one switch
  a_switch_onehot: assert property (@(posedge core_clk) disable iff (!rst_n)
    !ctl0_q[3] |-> $onehot(analog_ctl.switch_on));

  // The closed switch is the selected one
  a_switch_match: assert property (@(posedge core_clk) disable iff (!rst_n)
    !ctl0_q[3] |-> analog_ctl.switch_on[ctl0_q[2:0]]);

  // Level handed to the core is the {high, low} pair
  a_ref_level: assert property (@(posedge core_clk) disable iff (!rst_n)
    analog_ctl.ref_level == {ref_high_q, ctl0_q[REF_LOW_BIT]});

  // Any non-external pair turns the internal reference on
  a_ref_internal: assert property (@(posedge core_clk) disable iff (!rst_n)
    ref_pair != REF_EXTERNAL |-> analog_ctl.internal_ref_on);

  // Output bit set drives the buffered reference onto the pin
  a_ref_drive: assert property (@(posedge core_clk) disable iff (!rst_n)
    ctl0_q[REF_PIN_BIT] |-> ref_pin_oe && analog_ctl.ref_buffer_on);

  // High reference bit takes the written value
  a_ref_high_write: assert property (@(posedge core_clk) disable iff (!rst_n)
    (reg_wr && reg_addr == CTL1_OFFSET) |=> ref_high_q == $past(reg_wdata[REF_HIGH_BIT]));

  // High reference bit reads back in bit zero
  a_ref_high_read: assert property (@(posedge core_clk) disable iff (!rst_n)
    (reg_rd && reg_addr == CTL1_OFFSET) |=> reg_rdata == {7'h00, $past(ref_high_q)});

  // Writing one clears the flag when no completion competes
  a_irq_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
    (reg_wr && reg_addr == IRQ_STATUS_OFFSET && reg_wdata[0] && !done) |=> !irq_status_q);

  // Flag stays set until software clears it
  a_status_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    (irq_status_q && !(reg_wr && reg_addr == IRQ_STATUS_OFFSET)) |=> irq_status_q);

  // Mask takes the written value
  a_mask_write: assert property (@(posedge core_clk) disable iff (!rst_n)
    (reg_wr && reg_addr == IRQ_MASK_OFFSET) |=> irq_mask_q == $past(reg_wdata[0]));

  // Request line only with a set and unmasked flag
  a_irq_out: assert property (@(posedge core_clk) disable iff (!rst_n)
    irq |-> irq_status_q && irq_mask_q);

  // Status reads back in bit zero
  a_read_status: assert property (@(posedge core_clk) disable iff (!rst_n)
    (reg_rd && reg_addr == IRQ_STATUS_OFFSET) |=> reg_rdata == {7'h00, $past(irq_status_q)});

endmodule
`default_nettype wire

/* adc_ctl_pkg.sv */
// Purpose: Constants and types for the converter control register block
// Assumes: One 250 MHz system clock, byte-wide register port
// Notes: Register offsets are byte addresses on the plain register port
// Behaviour
// - Writing one to the conversion enable bit starts a conversion on the selected channel.
// - Writing one while a conversion runs abandons it and restarts from the beginning.
// - The enable bit reads one during a conversion and clears itself when it finishes.
// - Writing zero to the enable bit neither stops a conversion nor changes the bit.
// - The pair {high, low} selects the internal reference, 01 for 1.0 V and 10 for 2.0 V.
// - The pair 00 disables the internal reference and uses the external reference pin.
// - With the reference output bit at one the internal reference is buffered onto the pin.
// - With the reference output bit at zero the buffer is off and the pin is free for general use.
// - In single-shot mode one result is output once, 5129 cycles after the start.
// - In continuous mode a new result is output every 256 cycles.
// - Bits 3 to 0 select the analog input channel that is sampled.
// - Codes 0000 to 0111 pick inputs zero to seven; other codes open every input switch.
// - Each completed conversion raises a completion event; in continuous mode enable stays zero.
package adc_ctl_pkg;
  localparam logic [11:0] CTL0_OFFSET = 12'h0f70;
  localparam logic [11:0] CTL1_OFFSET = 12'h0f71;
  localparam logic [11:0] IRQ_STATUS_OFFSET = 12'h0f72;
  localparam logic [11:0] IRQ_MASK_OFFSET = 12'h0f73;
  localparam logic [7:0] CTL0_RESET = 8'h00;
  localparam logic [7:0] CTL1_RESET = 8'h00;
  localparam int ENABLE_BIT = 7;
  localparam int REF_LOW_BIT = 6;
  localparam int REF_PIN_BIT = 5;
  localparam int CONTINUOUS_MODE_BIT = 4;
  localparam int REF_HIGH_BIT = 0;
  localparam int SINGLE_CYCLES = 5129;
  localparam int CONTINUOUS_MODE_CYCLES = 256;
  localparam logic [3:0] LAST_CHANNEL = 4'h7;
  localparam logic [1:0] REF_EXTERNAL = 2'b00;
  localparam logic [1:0] REF_ONE_VOLT = 2'b01;
  localparam logic [1:0] REF_TWO_VOLT = 2'b10;

  typedef enum logic [1:0] {
    IDLE_ST = 2'b00,
    FIRST_ST = 2'b01,
    CONTINUOUS_MODE_ST = 2'b11
  } conv_state_type;

  // Settings handed to the analog core
  typedef struct packed {
    logic [7:0] switch_on;
    logic internal_ref_on;
    logic [1:0] ref_level;
    logic ref_buffer_on;
  } analog_ctl_type;
endpackage

/* tb.sv */
// Purpose: Self-checking bench for the converter control register block
// Assumes: Counts shortened to 20 and 8 cycles
// Notes: Strobe timing measured in whole cycles from the writing edge
`timescale 1ns/1ps
`default_nettype none
module tb;
  import adc_ctl_pkg::*;
  localparam int SC = 20;
  localparam int CC = 8;
  logic core_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0;
  logic [11:0] reg_addr = 12'h0000;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, rd_val;
  analog_ctl_type analog_ctl;
  logic sample_strobe, ref_pin_oe, irq;
  logic [3:0] input_channel_select;
  int num_errors = 0, checks = 0, n, cnt;
  adc_ctl #(.SINGLE_COUNT(SC), .CONTINUOUS_MODE_COUNT(CC)) uut (.core_clk(core_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .analog_ctl(analog_ctl), .sample_strobe(sample_strobe),
    .input_channel_select(input_channel_select), .ref_pin_oe(ref_pin_oe), .irq(irq));
  adc_core_model core (.core_clk(core_clk), .analog_ctl(analog_ctl),
    .sample_strobe(sample_strobe), .result_count(cnt));
  initial begin
    forever #2 core_clk = ~core_clk;
  end
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One-cycle strobes, changed just after the edge
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask
  // Bounded so a missing strobe cannot hang the run
  task automatic wait_strobe();
    n = 0;
    do begin
      @(posedge core_clk);
      #1 n++;
    end while (!sample_strobe && n < 100);
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #8000;
    num_errors++;
    conclude();
  end
  initial begin
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(CTL0_OFFSET); chk("ctl0 reset", rd_val, CTL0_RESET);
    wr(12'h0f7f, 8'hff); rd(12'h0f7f); chk("unmapped", rd_val, 0);
    wr(CTL0_OFFSET, 8'h85); rd(CTL0_OFFSET); chk("ctl0 run", rd_val, 8'h85);
    chk("switch", analog_ctl.switch_on, 8'h20);
    chk("channel", input_channel_select, 4'h5);
    wr(CTL0_OFFSET, 8'h05); rd(CTL0_OFFSET); chk("zero write", rd_val, 8'h85);
    wr(CTL0_OFFSET, 8'h85); wait_strobe(); chk("restart time", n, SC);
    rd(CTL0_OFFSET); chk("self clear", rd_val, 8'h05);
    rd(IRQ_STATUS_OFFSET); chk("status", rd_val, 8'h01);
    chk("irq masked", irq, 0);
    wr(IRQ_MASK_OFFSET, 8'h01); #1 chk("irq on", irq, 1);
    wr(IRQ_STATUS_OFFSET, 8'h01); #1 chk("irq off", irq, 0);
    // Every reference pair, pin buffer toggled, reserved channel code
    for (int i = 0; i < 4; i++) begin
      wr(CTL1_OFFSET, {7'h00, i[1]});
      wr(CTL0_OFFSET, {1'b0, i[0], i[1], 5'h08});
      #1 chk("ref level", analog_ctl.ref_level, i[1:0]);
      chk("ref on", analog_ctl.internal_ref_on, i[1] | i[0]);
      chk("buffer", analog_ctl.ref_buffer_on, i[1]);
      chk("pin oe", ref_pin_oe, i[1]);
      chk("reserved", analog_ctl.switch_on, 8'h00);
    end
    wr(CTL0_OFFSET, 8'h93); wait_strobe(); chk("first", n, SC);
    wait_strobe(); chk("period", n, CC);
    wait_strobe(); chk("period 2", n, CC);
    rd(CTL0_OFFSET); chk("continuous_mode enable", rd_val, 8'h13);
    wr(CTL0_OFFSET, 8'h03); #1 n = cnt;
    repeat (30) @(posedge core_clk);
    chk("stopped", cnt - n, 0);
    conclude();
  end
endmodule
`default_nettype wire
